// ---- core/mlca_modem_ctl.sv ----
// Modem line control and auto-answer, terminal and access unit sides
//
// Notes on behaviour
// R1 - Carrier detect only while a demodulable signal arrives; data then valid.
// R2 - Ring indicate to terminal while the line calling signal is detected.
// R3 - Terminal sends transmit data inverted: up is 0, down is 1.
// R4 - Square transmit clock at bit rate, running whenever powered.
// R5 - Square receive clock at bit rate for sampling received data.
// R6 - Received data inverted the same way: up is 0, down is 1.
// R7 - New sync line stays unused and inactive by both parties.
// R8 - Off-hook high seizes the line, otherwise low.
// R9 - Modem-ready held high whenever switched operation is selected.
// R10 - Access unit raises ring while it detects ringing.
// R11 - Cut-through high means ready; low is treated as not ready.
// R12 - Switch-hook high only with handset off and exclusion key out.
// R13 - Answer ring with off-hook only when terminal ready is on.
// R14 - Answer tone of 2100 Hz starts 3 to 4 s after cut-through.
// R15 - At tone end, raise data set ready to hand over to terminal.
// R16 - Terminal raises terminal ready when its adapter is activated.
// R17 - Switched: data set ready means connected and ready for control.
// R18 - Clear to send only after request to send is on.
// R19 - Terminal ready dropped ends the call: off-hook and ready fall.
`timescale 1ns/1ps
`default_nettype none
`include "mlca_params.svh"

module mlca_modem_ctl #(
   parameter logic [31:0] TONE_DELAY_CYC = `MLCA_TONE_DELAY_CYC,
   parameter logic [31:0] TONE_LEN_CYC   = `MLCA_TONE_LEN_CYC,
   parameter logic [31:0] TONE_HALF_CYC  = `MLCA_TONE_HALF_CYC
) (
   input  wire logic clock_i,
   input  wire logic arst_n_i,
   input  wire logic link_clk_i,
   // Terminal side
   input  wire logic dtr_i,
   input  wire logic rts_i,
   input  wire logic txd_i,
   input  wire logic switched_sel_i,
   output logic      carrier_detect_o,
   output logic      ring_indicate_o,
   output logic      dsr_o,
   output logic      cts_o,
   output logic      rxd_o,
   output logic      tx_clock_o,
   output logic      rx_clock_o,
   output logic      new_sync_o,
   // Access unit side
   input  wire logic ring_in_i,
   input  wire logic cut_through_in_i,
   input  wire logic handset_lifted_in_i,
   output logic      line_seize_out_o,
   output logic      modem_ready_out_o,
   output logic      answer_tone_o,
   // Demodulator and modulator, link clock domain
   input  wire logic demod_bit_i,
   input  wire logic demod_stb_i,
   input  wire logic signal_ok_i,
   output logic      demod_ready_o,
   output logic      line_tx_bit_o
);
   localparam logic [15:0] BIT_HALF = 16'(`MLCA_BIT_HALF_CYC);

   typedef struct packed {
      logic [1:0]           dtr;
      logic [1:0]           rts;
      logic [1:0]           txd;
      logic [1:0]           sw;
      logic [1:0]           ring;
      logic [1:0]           cut;
      logic [1:0]           hook;
      logic [1:0]           ok;
      logic [1:0]           req;
      mlca_pkg::mlca_state_t fsm;
      logic [31:0]          cnt;
      logic [31:0]          tone_cnt;
      logic                 tone;
      logic [15:0]          div;
      logic                 bclk;
      logic                 tx_bit;
      logic                 rxd;
      logic                 ack;
      logic                 cd;
      logic                 ri;
      logic                 dsr;
      logic                 cts;
      logic                 seize;
      logic                 ready;
      logic                 nsync;
   } mlca_ctl_st_t;

   mlca_ctl_st_t st;
   mlca_ctl_st_t next_st;

   logic link_req;
   logic link_data;
   logic link_ok;
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready;
   logic fifo_out_data;

   // Terminal ready with switched mode, as the call may go on
   function automatic logic call_allowed(input logic dtr, input logic sw);
      call_allowed = dtr && sw;
   endfunction : call_allowed

   mlca_link u_link (
      .link_clk_i    (link_clk_i),
      .arst_n_i      (arst_n_i),
      .demod_bit_i   (demod_bit_i),
      .demod_stb_i   (demod_stb_i),
      .signal_ok_i   (signal_ok_i),
      .demod_ready_o (demod_ready_o),
      .req_o         (link_req),
      .data_o        (link_data),
      .ok_o          (link_ok),
      .ack_i         (st.ack),
      .tx_bit_i      (st.tx_bit),
      .line_tx_bit_o (line_tx_bit_o)
   );

   mlca_fifo #(
      .WIDTH (`MLCA_FIFO_WIDTH),
      .DEPTH (`MLCA_FIFO_DEPTH)
   ) u_fifo (
      .clock_i     (clock_i),
      .arst_n_i    (arst_n_i),
      .in_valid_i  (fifo_in_valid),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (link_data),
      .out_valid_o (fifo_out_valid),
      .out_ready_i (fifo_out_ready),
      .out_data_o  (fifo_out_data)
   );

   // A pending link bit is pushed only while carrier is present
   always_comb begin
      logic pending;
      logic falling;
      pending        = 1'b0;
      falling        = 1'b0;
      pending        = (st.req[1] != st.ack);
      falling        = (st.div == BIT_HALF - 16'h0001) && st.bclk;
      fifo_in_valid  = pending && st.ok[1];                     // [R1]
      fifo_out_ready = falling && st.cd;                        // [R1]
   end

   always_comb begin
      logic pending;
      logic rising;
      logic falling;
      pending = 1'b0;
      rising  = 1'b0;
      falling = 1'b0;
      next_st = st;

      // Two flip-flop synchronisers for every pin and the link levels
      next_st.dtr  = {st.dtr[0], dtr_i};
      next_st.rts  = {st.rts[0], rts_i};
      next_st.txd  = {st.txd[0], txd_i};
      next_st.sw   = {st.sw[0], switched_sel_i};
      next_st.ring = {st.ring[0], ring_in_i};
      next_st.cut  = {st.cut[0], cut_through_in_i};
      next_st.hook = {st.hook[0], handset_lifted_in_i};
      next_st.ok   = {st.ok[0], link_ok};
      next_st.req  = {st.req[0], link_req};

      // Bit clock divider, free running from reset
      rising  = 1'b0;
      falling = 1'b0;
      if (st.div == BIT_HALF - 16'h0001) begin
         next_st.div  = 16'h0000;
         next_st.bclk = ~st.bclk;                               // [R4] [R5]
         rising       = ~st.bclk;
         falling      = st.bclk;
      end else begin
         next_st.div = st.div + 16'h0001;
      end

      // Sample terminal data at the rising edge, undo inversion
      if (rising) begin
         next_st.tx_bit = ~st.txd[1];                           // [R3]
      end

      // Drive received data on the falling edge, inverted
      if (falling) begin
         if (st.cd && fifo_out_valid) begin
            next_st.rxd = ~fifo_out_data;                       // [R6]
         end else begin
            next_st.rxd = 1'b0;                                 // [R6]
         end
      end

      // Hand-shake the link bit; a full buffer stalls the link side
      pending = (st.req[1] != st.ack);
      if (pending && (fifo_in_ready || !st.ok[1])) begin
         next_st.ack = ~st.ack;
      end

      next_st.cd    = st.ok[1];                                 // [R1]
      next_st.ri    = st.ring[1];                               // [R2]
      next_st.ready = st.sw[1];                                 // [R9]
      next_st.nsync = `MLCA_RST_LOW;                            // [R7]

      // Auto-answer sequence
      case (st.fsm)
         mlca_pkg::MLCA_IDLE: begin
            next_st.cnt = 32'h0000_0000;
            // Operator holding the handset keeps the call manual
            if (st.ring[1] && !st.hook[1] &&
                call_allowed(st.dtr[1], st.sw[1])) begin        // [R13]
               next_st.fsm = mlca_pkg::MLCA_SEIZE;
            end
         end
         mlca_pkg::MLCA_SEIZE: begin
            next_st.cnt = 32'h0000_0000;
            if (!call_allowed(st.dtr[1], st.sw[1])) begin       // [R19]
               next_st.fsm = mlca_pkg::MLCA_IDLE;
            end else if (st.cut[1]) begin                       // [R11]
               next_st.fsm = mlca_pkg::MLCA_WAIT;
            end
         end
         mlca_pkg::MLCA_WAIT: begin
            if (!call_allowed(st.dtr[1], st.sw[1])) begin       // [R19]
               next_st.fsm = mlca_pkg::MLCA_IDLE;
            end else if (!st.cut[1]) begin                      // [R11]
               next_st.fsm = mlca_pkg::MLCA_SEIZE;
            end else if (st.cnt == TONE_DELAY_CYC - 32'h1) begin // [R14]
               next_st.fsm      = mlca_pkg::MLCA_TONE;
               next_st.cnt      = 32'h0000_0000;
               next_st.tone_cnt = 32'h0000_0000;
            end else begin
               next_st.cnt = st.cnt + 32'h1;
            end
         end
         mlca_pkg::MLCA_TONE: begin
            if (!call_allowed(st.dtr[1], st.sw[1]) ||
                !st.cut[1]) begin                               // [R19]
               next_st.fsm = mlca_pkg::MLCA_IDLE;
            end else if (st.cnt == TONE_LEN_CYC - 32'h1) begin  // [R15]
               next_st.fsm = mlca_pkg::MLCA_CONN;
            end else begin
               next_st.cnt = st.cnt + 32'h1;
            end
            // 2100 Hz square wave toward the line coupler
            if (st.tone_cnt == TONE_HALF_CYC - 32'h1) begin     // [R14]
               next_st.tone_cnt = 32'h0000_0000;
               next_st.tone     = ~st.tone;
            end else begin
               next_st.tone_cnt = st.tone_cnt + 32'h1;
            end
         end
         mlca_pkg::MLCA_CONN: begin
            // Coupler going inoperative counts as a lost line
            if (!call_allowed(st.dtr[1], st.sw[1]) ||
                !st.cut[1]) begin                               // [R19]
               next_st.fsm = mlca_pkg::MLCA_IDLE;
            end
         end
         default: begin
            next_st.fsm = mlca_pkg::MLCA_IDLE;
         end
      endcase

      if (next_st.fsm != mlca_pkg::MLCA_TONE) begin
         next_st.tone = 1'b0;
      end
      next_st.seize = (next_st.fsm != mlca_pkg::MLCA_IDLE);     // [R8]
      // Leased line: ready means powered; switched: connected
      next_st.dsr = (next_st.fsm == mlca_pkg::MLCA_CONN) ||
                    !st.sw[1];                                  // [R15] [R17]
      // Follows request to send, three cycles later, once connected
      next_st.cts = st.rts[1] && st.dsr;                        // [R18]
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st     <= '0;
         st.fsm <= mlca_pkg::MLCA_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign new_sync_o        = st.nsync;
   assign carrier_detect_o  = st.cd;
   assign ring_indicate_o   = st.ri;
   assign dsr_o             = st.dsr;
   assign cts_o             = st.cts;
   assign rxd_o             = st.rxd;
   assign tx_clock_o        = st.bclk;
   assign rx_clock_o        = st.bclk;
   assign line_seize_out_o  = st.seize;
   assign modem_ready_out_o = st.ready;
   assign answer_tone_o     = st.tone;

endmodule : mlca_modem_ctl

`default_nettype wire

// ---- core/mlca_params.svh ----
// Timing and sizing constants of the modem line control block
`ifndef MLCA_PARAMS_SVH
`define MLCA_PARAMS_SVH

// System clock rate in Hz
`define MLCA_CLK_HZ          25000000
// Line bit rate in Hz for the bit clocks
`define MLCA_BIT_RATE_HZ     9600
// Half period of the bit clocks in system cycles
`define MLCA_BIT_HALF_CYC    (`MLCA_CLK_HZ / (2 * `MLCA_BIT_RATE_HZ))
// Answer tone frequency in Hz
`define MLCA_TONE_FREQ_HZ    2100
// Half period of the answer tone in system cycles
`define MLCA_TONE_HALF_CYC   (`MLCA_CLK_HZ / (2 * `MLCA_TONE_FREQ_HZ))
// Least wait from cut-through to tone start, in ms
`define MLCA_TONE_DELAY_MS   3000
`define MLCA_TONE_DELAY_CYC  (`MLCA_TONE_DELAY_MS * (`MLCA_CLK_HZ / 1000))
// Length of the answer tone, in ms
`define MLCA_TONE_LEN_MS     3000
`define MLCA_TONE_LEN_CYC    (`MLCA_TONE_LEN_MS * (`MLCA_CLK_HZ / 1000))
// Receive buffer shape
`define MLCA_FIFO_WIDTH      1
`define MLCA_FIFO_DEPTH      16
// Reset levels of the control outputs
`define MLCA_RST_LOW         1'h0

`endif

// ---- core/mlca_pkg.sv ----
// Types shared by the modem line control block
package mlca_pkg;

   typedef enum logic [2:0] {
      MLCA_IDLE,
      MLCA_SEIZE,
      MLCA_WAIT,
      MLCA_TONE,
      MLCA_CONN
   } mlca_state_t;

endpackage : mlca_pkg

// ---- core/mlca_fifo.sv ----
// Single clock receive buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module mlca_fifo #(
   parameter int WIDTH = 1,
   parameter int DEPTH = 16
) (
   input  wire logic             clock_i,
   input  wire logic             arst_n_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
   } mlca_fifo_st_t;

   mlca_fifo_st_t st;
   mlca_fifo_st_t next_st;
   logic          push;
   logic          pop;

   always_comb begin
      next_st     = st;
      in_ready_o  = (st.cnt != DEPTH[AW:0]);
      out_valid_o = (st.cnt != '0);
      out_data_o  = st.mem[st.rd];
      push        = in_valid_i && in_ready_o;
      pop         = out_ready_i && out_valid_o;
      if (push) begin
         next_st.mem[st.wr] = in_data_i;
         next_st.wr         = st.wr + 1'b1;
      end
      if (pop) begin
         next_st.rd = st.rd + 1'b1;
      end
      if (push && !pop) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (pop && !push) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : mlca_fifo

`default_nettype wire

// ---- core/mlca_link.sv ----
// Link clock side: demodulated bits in, line transmit bit out
`timescale 1ns/1ps
`default_nettype none

module mlca_link (
   input  wire logic link_clk_i,
   input  wire logic arst_n_i,
   input  wire logic demod_bit_i,
   input  wire logic demod_stb_i,
   input  wire logic signal_ok_i,
   output logic      demod_ready_o,
   output logic      req_o,
   output logic      data_o,
   output logic      ok_o,
   input  wire logic ack_i,
   input  wire logic tx_bit_i,
   output logic      line_tx_bit_o
);
   typedef struct packed {
      logic [1:0] ack_s;
      logic [1:0] tx_s;
      logic       req;
      logic       data;
      logic       ok;
      logic       ready;
      logic       tx_out;
   } mlca_link_st_t;

   mlca_link_st_t st;
   mlca_link_st_t next_st;

   always_comb begin
      next_st          = st;
      next_st.ack_s[0] = ack_i;
      next_st.ack_s[1] = st.ack_s[0];
      next_st.tx_s[0]  = tx_bit_i;
      next_st.tx_s[1]  = st.tx_s[0];
      next_st.tx_out   = st.tx_s[1];
      next_st.ok       = signal_ok_i;
      // One bit in flight; the demodulator stalls until it is taken
      if (demod_stb_i && (st.req == st.ack_s[1])) begin
         next_st.data = demod_bit_i;
         next_st.req  = ~st.req;
      end
      // Read only the second sync stage; ready may come a cycle late
      next_st.ready = (next_st.req == st.ack_s[1]);
   end

   always_ff @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign demod_ready_o = st.ready;
   assign req_o         = st.req;
   assign data_o        = st.data;
   assign ok_o          = st.ok;
   assign line_tx_bit_o = st.tx_out;

endmodule : mlca_link

`default_nettype wire

// ---- tb/mlca_asserts.sv ----
// Port checker of the modem line control block
`timescale 1ns/1ps
`default_nettype none
`include "mlca_params.svh"
module mlca_asserts #(
   parameter logic [31:0] TONE_DELAY_CYC = 32'h0000_00C8
) (
   input wire logic clock_i,
   input wire logic arst_n_i,
   input wire logic rts_i,
   input wire logic dtr_i,
   input wire logic switched_sel_i,
   input wire logic ring_in_i,
   input wire logic cut_through_in_i,
   input wire logic new_sync_o,
   input wire logic modem_ready_out_o,
   input wire logic ring_indicate_o,
   input wire logic line_seize_out_o,
   input wire logic dsr_o,
   input wire logic cts_o,
   input wire logic answer_tone_o,
   input wire logic tx_clock_o,
   input wire logic rx_clock_o
);
   localparam int HALF = `MLCA_BIT_HALF_CYC;
   logic [15:0] half_cnt;
   logic        prev_clk;
   logic        seen;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!arst_n_i);
   // First gap after reset is not trusted, its phase is free
   always_ff @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         half_cnt <= 16'h0000;
         prev_clk <= 1'b0;
         seen <= 1'b0;
      end else begin
         prev_clk <= tx_clock_o;
         if (tx_clock_o != prev_clk) begin
            half_cnt <= 16'h0001;
            seen <= 1'b1;
         end else begin
            half_cnt <= half_cnt + 16'h0001;
         end
      end
   end
   a_sync_idle: assert property (!new_sync_o)
      else $error("new sync driven");
   a_ready_follow: assert property (
      $stable(switched_sel_i)[*4] |-> modem_ready_out_o == switched_sel_i)
      else $error("modem ready wrong");
   a_ring_follow: assert property (
      $stable(ring_in_i)[*4] |-> ring_indicate_o == ring_in_i)
      else $error("ring indicate wrong");
   a_seize_dtr: assert property (!dtr_i[*6] |-> !line_seize_out_o)
      else $error("seized without terminal ready");
   a_dsr_conn: assert property (
      switched_sel_i[*6] ##0 $rose(dsr_o) |->
      line_seize_out_o && cut_through_in_i)
      else $error("ready without line");
   a_cts_dsr: assert property (cts_o |-> $past(dsr_o))
      else $error("clear to send without ready");
   a_cts_rts: assert property (!rts_i[*5] |-> !cts_o)
      else $error("clear to send without request");
   a_tone_cut: assert property (
      $rose(answer_tone_o) |-> $past(cut_through_in_i, TONE_DELAY_CYC))
      else $error("tone too early");
   a_clk_pair: assert property (tx_clock_o == rx_clock_o)
      else $error("bit clocks differ");
   a_clk_half: assert property (
      seen && $changed(tx_clock_o) |-> half_cnt == HALF)
      else $error("bit clock half period wrong");
   a_clk_runs: assert property (seen |-> half_cnt <= HALF)
      else $error("bit clock stopped");
   c_seize: cover property ($rose(line_seize_out_o));
   c_handover: cover property ($rose(dsr_o) && switched_sel_i);
   c_cts: cover property ($rose(cts_o));
endmodule : mlca_asserts
`default_nettype wire

// ---- tb/mlca_far.sv ----
// Access unit and demodulator model at the far side of the block
`timescale 1ns/1ps
`default_nettype none
module mlca_far (
   input wire logic clock_i,
   input wire logic link_clk_i,
   input wire logic arst_n_i,
   input wire logic ring_cmd_i,
   input wire logic hook_cmd_i,
   input wire logic coupler_ok_i,
   input wire logic rx_go_i,
   input wire logic ok_cmd_i,
   input wire logic [15:0] rx_pat_i,
   input wire logic seize_i,
   input wire logic demod_ready_i,
   output logic ring_in_o,
   output logic cut_through_o,
   output logic handset_o,
   output logic demod_bit_o,
   output logic demod_stb_o,
   output logic signal_ok_o
);
   logic [3:0] cut_sh;
   logic [1:0] go_s;
   logic [4:0] idx;
   assign ring_in_o = ring_cmd_i;
   assign handset_o = hook_cmd_i;
   assign cut_through_o = cut_sh[3];
   // Coupler takes a few cycles after seizure to pass the line
   always @(posedge clock_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cut_sh <= 4'h0;
      end else begin
         cut_sh <= {cut_sh[2:0], seize_i & coupler_ok_i};
      end
   end
   // Data toggles between strobes so a stale bit never looks valid
   always @(posedge link_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         go_s <= 2'h0;
         idx <= 5'h00;
         demod_stb_o <= 1'b0;
         demod_bit_o <= 1'b0;
         signal_ok_o <= 1'b0;
      end else begin
         go_s <= {go_s[0], rx_go_i};
         signal_ok_o <= ok_cmd_i;
         if (!go_s[1]) begin
            idx <= 5'h00;
         end
         if (go_s[1] && idx < 5'h14 && demod_ready_i && !demod_stb_o) begin
            demod_stb_o <= 1'b1;
            demod_bit_o <= rx_pat_i[idx[3:0]];
            idx <= idx + 5'h01;
         end else begin
            demod_stb_o <= 1'b0;
            demod_bit_o <= ~demod_bit_o;
         end
      end
   end
endmodule : mlca_far
`default_nettype wire

// ---- tb/mlca_modem_ctl_tb.sv ----
// Self-checking bench of the modem line control block
`timescale 1ns/1ps
`default_nettype none
module mlca_modem_ctl_tb;
   localparam int DLY = 200;
   localparam int LEN = 300;
   localparam int TH = 5;
   logic clock_i, link_clk_i, arst_n_i, dtr_i, rts_i, txd_i;
   logic switched_sel_i, ring_in_i, cut_through_in_i, handset_lifted_in_i;
   logic demod_bit_i, demod_stb_i, signal_ok_i, carrier_detect_o;
   logic ring_indicate_o, dsr_o, cts_o, rxd_o, tx_clock_o, rx_clock_o;
   logic new_sync_o, line_seize_out_o, modem_ready_out_o, answer_tone_o;
   logic demod_ready_o, line_tx_bit_o, ring_cmd, hook_cmd, rx_go, ok_cmd;
   logic [15:0] pat;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   int n;
   mlca_modem_ctl #(
      .TONE_DELAY_CYC(DLY), .TONE_LEN_CYC(LEN), .TONE_HALF_CYC(TH)
   ) dut_u (
      .clock_i, .arst_n_i, .link_clk_i, .dtr_i, .rts_i, .txd_i,
      .switched_sel_i, .carrier_detect_o, .ring_indicate_o, .dsr_o,
      .cts_o, .rxd_o, .tx_clock_o, .rx_clock_o, .new_sync_o, .ring_in_i,
      .cut_through_in_i, .handset_lifted_in_i, .line_seize_out_o,
      .modem_ready_out_o, .answer_tone_o, .demod_bit_i, .demod_stb_i,
      .signal_ok_i, .demod_ready_o, .line_tx_bit_o
   );
   mlca_far far_u (
      .clock_i, .link_clk_i, .arst_n_i, .ring_cmd_i(ring_cmd),
      .hook_cmd_i(hook_cmd), .coupler_ok_i(1'b1), .rx_go_i(rx_go),
      .ok_cmd_i(ok_cmd), .rx_pat_i(pat), .seize_i(line_seize_out_o),
      .demod_ready_i(demod_ready_o), .ring_in_o(ring_in_i),
      .cut_through_o(cut_through_in_i), .handset_o(handset_lifted_in_i),
      .demod_bit_o(demod_bit_i), .demod_stb_o(demod_stb_i),
      .signal_ok_o(signal_ok_i)
   );
   task automatic end_sim;
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s exp %b got %b", nm, e, g);
      end
   endtask : chk
   task automatic chk_rng(input string nm, input int lo, hi, v);
      checked++;
      if (v < lo || v > hi) begin
         failures++;
         $display("unexpected %s exp %0d..%0d got %0d", nm, lo, hi, v);
      end
   endtask : chk_rng
   // Outputs are read at the falling edge, where they have settled
   task automatic wt(input int k);
      repeat (k) @(negedge clock_i);
   endtask : wt
   task automatic wait_for(input string nm, ref logic s, input logic v,
                           input int lim);
      n = 0;
      while (s !== v && n < lim) begin
         wt(1);
         n++;
      end
      chk(nm, v, s);
   endtask : wait_for
   task automatic edge_of(input logic rx, input logic lvl);
      int k;
      k = 0;
      while ((rx ? rx_clock_o : tx_clock_o) !== !lvl && k < 3000) begin
         wt(1);
         k++;
      end
      while ((rx ? rx_clock_o : tx_clock_o) !== lvl && k < 6000) begin
         wt(1);
         k++;
      end
      chk_rng("bit clock edge", 0, 5999, k);
      wt(2);
   endtask : edge_of
   task automatic t_idle;
      wt(6);
      chk("new_sync", 1'b0, new_sync_o);
      chk("modem_ready", 1'b1, modem_ready_out_o);
      chk("line_seize", 1'b0, line_seize_out_o);
      chk("dsr", 1'b0, dsr_o);
      chk("carrier", 1'b0, carrier_detect_o);
   endtask : t_idle
   task automatic t_refuse;
      @(posedge clock_i);
      ring_cmd <= 1'b1;
      hook_cmd <= 1'b1;
      wt(10);
      chk("ring_indicate", 1'b1, ring_indicate_o);
      chk("seize no dtr", 1'b0, line_seize_out_o);
      @(posedge clock_i);
      dtr_i <= 1'b1;
      wt(10);
      chk("seize handset up", 1'b0, line_seize_out_o);
      @(posedge clock_i);
      ring_cmd <= 1'b0;
      wt(10);
      chk("ring_indicate", 1'b0, ring_indicate_o);
   endtask : t_refuse
   task automatic t_answer;
      @(posedge clock_i);
      hook_cmd <= 1'b0;
      ring_cmd <= 1'b1;
      rts_i <= 1'b1;
      wait_for("line_seize", line_seize_out_o, 1'b1, 10);
      @(posedge clock_i);
      ring_cmd <= 1'b0;
      wait_for("tone", answer_tone_o, 1'b1, 400);
      chk_rng("tone delay", DLY, DLY * 4 / 3, n);
      wait_for("tone low", answer_tone_o, 1'b0, 20);
      chk_rng("tone half", TH - 1, TH + 1, n);
      wait_for("dsr", dsr_o, 1'b1, LEN + 50);
      chk_rng("tone length", LEN - 20, LEN + 10, n);
      wt(6);
      chk("cts", 1'b1, cts_o);
      @(posedge clock_i);
      rts_i <= 1'b0;
      wt(6);
      chk("cts", 1'b0, cts_o);
      @(posedge clock_i);
      dtr_i <= 1'b0;
      wt(8);
      chk("seize end", 1'b0, line_seize_out_o);
      chk("dsr end", 1'b0, dsr_o);
   endtask : t_answer
   task automatic t_nonsw;
      @(posedge clock_i);
      switched_sel_i <= 1'b0;
      rts_i <= 1'b1;
      wt(8);
      chk("modem_ready", 1'b0, modem_ready_out_o);
      chk("cts", 1'b1, cts_o);
      @(posedge clock_i);
      switched_sel_i <= 1'b1;
      rts_i <= 1'b0;
      wt(8);
      chk("dsr idle", 1'b0, dsr_o);
   endtask : t_nonsw
   // Bits arrive far faster than the bit clock drains them
   task automatic t_rx;
      @(posedge clock_i);
      ok_cmd <= 1'b1;
      wt(12);
      chk("carrier", 1'b1, carrier_detect_o);
      edge_of(1'b1, 1'b0);
      @(posedge clock_i);
      pat <= 16'hA5C3;
      rx_go <= 1'b1;
      wt(1000);
      chk("buffer full", 1'b0, demod_ready_o);
      for (int k = 0; k < 16; k++) begin
         edge_of(1'b1, 1'b0);
         chk("rxd", ~pat[k], rxd_o);
      end
      @(posedge clock_i);
      rx_go <= 1'b0;
      ok_cmd <= 1'b0;
      wt(12);
      chk("carrier", 1'b0, carrier_detect_o);
      edge_of(1'b1, 1'b0);
      chk("rxd mark", 1'b0, rxd_o);
   endtask : t_rx
   task automatic t_tx;
      for (int v = 1; v >= 0; v--) begin
         @(posedge clock_i);
         txd_i <= v[0];
         wt(4);
         edge_of(1'b0, 1'b1);
         wt(10);
         chk("line_tx_bit", ~v[0], line_tx_bit_o);
      end
   endtask : t_tx
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   initial begin
      link_clk_i = 1'b0;
      #7;
      forever #15 link_clk_i = ~link_clk_i;
   end
   always @(posedge clock_i) begin
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      arst_n_i = 1'b0;
      dtr_i = 1'b0;
      rts_i = 1'b0;
      txd_i = 1'b0;
      switched_sel_i = 1'b1;
      ring_cmd = 1'b0;
      hook_cmd = 1'b0;
      rx_go = 1'b0;
      ok_cmd = 1'b0;
      pat = 16'h0000;
      repeat (2) @(posedge clock_i);
      arst_n_i <= 1'b1;
      t_idle();
      t_refuse();
      t_answer();
      t_nonsw();
      t_rx();
      t_tx();
      end_sim();
   end
endmodule : mlca_modem_ctl_tb
bind mlca_modem_ctl mlca_asserts #(.TONE_DELAY_CYC(TONE_DELAY_CYC)) chk_u (
   .clock_i, .arst_n_i, .rts_i, .dtr_i, .switched_sel_i, .ring_in_i,
   .cut_through_in_i, .new_sync_o, .modem_ready_out_o, .ring_indicate_o,
   .line_seize_out_o, .dsr_o, .cts_o, .answer_tone_o, .tx_clock_o,
   .rx_clock_o
);
`default_nettype wire
